// *** common/ffp_pkg.sv ***
/*
  Constants and types shared by the four-phase fetch/execute pipeline
  controller: phase encodings, oscillator selection codes, reset vector,
  instruction-class encodings and field layouts.
  Assumes nothing of its surroundings.
*/
package ffp_pkg;

  // ===========================================================
  // widths and vectors
  localparam int PC_W = 13;
  localparam int INSTR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ===========================================================
  // oscillator sources
  typedef enum logic [1:0] {
    FFP_SRC_EXT_FAST = 2'b00,
    FFP_SRC_EXT_SLOW = 2'b01,
    FFP_SRC_INT_FAST = 2'b10,
    FFP_SRC_INT_SLOW = 2'b11
  } ffp_src_t;

  // ===========================================================
  // instruction phases
  typedef enum logic [1:0] {
    FFP_PH1 = 2'b00,
    FFP_PH2 = 2'b01,
    FFP_PH3 = 2'b10,
    FFP_PH4 = 2'b11
  } ffp_phase_t;

  // ===========================================================
  // sequencer states
  typedef enum logic [1:0] {
    FFP_ST_NORMAL = 2'b00,
    FFP_ST_EXT2 = 2'b01,
    FFP_ST_BRANCH = 2'b10,
    FFP_ST_DUMMY = 2'b11
  } ffp_state_t;

  // ===========================================================
  // instruction word fields: [15:12] opcode class, [11:8] alu op,
  // [7:0] immediate; jumps use [12:0] as target with class 4'h8/4'h9
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 12;
  localparam int ALU_HI = 11;
  localparam int ALU_LO = 8;
  localparam logic [3:0] OPC_NOP = 4'h0;
  localparam logic [3:0] OPC_ALU = 4'h1;
  localparam logic [3:0] OPC_ALU_EXT = 4'h2;
  localparam logic [3:0] OPC_SKIP_Z = 4'h3;
  localparam logic [3:0] OPC_SKIP_NZ = 4'h4;
  localparam logic [3:0] OPC_JUMP = 4'h8;
  localparam logic [3:0] OPC_CALL = 4'h9;

  // alu operations
  localparam logic [3:0] ALU_MOV = 4'h0;
  localparam logic [3:0] ALU_ADD = 4'h1;
  localparam logic [3:0] ALU_SUB = 4'h2;
  localparam logic [3:0] ALU_AND = 4'h3;
  localparam logic [3:0] ALU_OR = 4'h4;
  localparam logic [3:0] ALU_XOR = 4'h5;
  localparam logic [3:0] ALU_CPL = 4'h6;
  localparam logic [3:0] ALU_RR = 4'h7;
  localparam logic [3:0] ALU_RL = 4'h8;
  localparam logic [3:0] ALU_INC = 4'h9;
  localparam logic [3:0] ALU_DEC = 4'hA;

  // clock divider: phase advances once per divided tick
  localparam logic [7:0] DIV_EXT_FAST = 8'h00;
  localparam logic [7:0] DIV_EXT_SLOW = 8'h07;
  localparam logic [7:0] DIV_INT_FAST = 8'h01;
  localparam logic [7:0] DIV_INT_SLOW = 8'h0F;

endpackage

// *** verilog/ffp_pipeline.sv ***
/*
  Four-phase fetch/execute pipeline controller with an 8-bit ALU and
  accumulator. Fetches instruction words from program memory in phase 1
  of each instruction cycle except the second cycle of an extended instruction, while the previous word executes.
  Assumes program memory returns the word for prog_addr combinationally
  (valid in the same mclk cycle as prog_rd); no register bus.
*/
// Behaviour
// - four non-overlapping phases from system clock
// - pc increments and fetches in phase one
// - phases two to four decode and execute
// - four phases form one instruction cycle
// - next fetch overlaps current execution
// - standard one cycle, extended two cycles
// - branches take one extra cycle
// - single 8-bit ALU for all operations
// - data moves through accumulator and ALU
// - phase clock from one of four sources
// - taken skip discards prefetch, inserts dummy
// - fetching restarts at address zero after reset
`timescale 1ns/1ns
`default_nettype none
module ffp_pipeline
  import ffp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] osc_select,
  output logic [PC_W-1:0] prog_addr,
  output logic prog_rd,
  input wire logic [INSTR_W-1:0] prog_data,
  output logic [3:0] instruction_phase_clocks,
  output logic cycle_start,
  output logic [PC_W-1:0] pc,
  output logic [DATA_W-1:0] acc,
  output logic zero_flag,
  output logic carry_flag,
  output logic [1:0] seq_state,
  output logic exec_valid
);

  // ===========================================================
  // state
  typedef struct packed {
    logic [7:0] div_cnt;
    ffp_phase_t phase;
    ffp_state_t state;
    logic [PC_W-1:0] pc;
    logic [INSTR_W-1:0] fetched;
    logic fetched_valid;
    logic [INSTR_W-1:0] exec_ir;
    logic exec_valid;
    logic [DATA_W-1:0] acc;
    logic zf;
    logic cf;
    logic [3:0] phase_oh;
    logic cyc_start;
  } ffp_regs_t;

  ffp_regs_t r;
  ffp_regs_t next_r;

  logic [7:0] div_limit;
  logic tick;
  logic [3:0] opc;
  logic [3:0] aop;
  logic [DATA_W-1:0] imm;
  logic [DATA_W:0] alu_res;
  logic is_branch;
  logic is_ext;
  logic skip_taken;

  // ===========================================================
  // source selection and divider
  always_comb begin
    unique case (ffp_src_t'(osc_select))
      FFP_SRC_EXT_FAST: div_limit = DIV_EXT_FAST;
      FFP_SRC_EXT_SLOW: div_limit = DIV_EXT_SLOW;
      FFP_SRC_INT_FAST: div_limit = DIV_INT_FAST;
      FFP_SRC_INT_SLOW: div_limit = DIV_INT_SLOW;
    endcase
  end
  assign tick = (r.div_cnt >= div_limit);

  // ===========================================================
  // decode of the instruction in execution
  assign opc = r.exec_ir[OPC_HI:OPC_LO];
  assign aop = r.exec_ir[ALU_HI:ALU_LO];
  assign imm = r.exec_ir[DATA_W-1:0];
  assign is_branch = r.exec_valid && (opc == OPC_JUMP || opc == OPC_CALL);
  assign is_ext = r.exec_valid && (opc == OPC_ALU_EXT);
  assign skip_taken = r.exec_valid &&
    ((opc == OPC_SKIP_Z && r.zf) || (opc == OPC_SKIP_NZ && !r.zf));

  // single ALU, every result lands in the accumulator
  always_comb begin
    unique case (aop)
      ALU_MOV: alu_res = {1'b0, imm};
      ALU_ADD: alu_res = {1'b0, r.acc} + {1'b0, imm};
      ALU_SUB: alu_res = {1'b0, r.acc} - {1'b0, imm};
      ALU_AND: alu_res = {1'b0, r.acc & imm};
      ALU_OR: alu_res = {1'b0, r.acc | imm};
      ALU_XOR: alu_res = {1'b0, r.acc ^ imm};
      ALU_CPL: alu_res = {1'b0, ~r.acc};
      ALU_RR: alu_res = {r.acc[0], r.acc[0], r.acc[DATA_W-1:1]};
      ALU_RL: alu_res = {r.acc[DATA_W-1], r.acc[DATA_W-2:0],
                         r.acc[DATA_W-1]};
      ALU_INC: alu_res = {1'b0, r.acc} + 9'h001;
      ALU_DEC: alu_res = {1'b0, r.acc} - 9'h001;
      default: alu_res = {1'b0, r.acc};
    endcase
  end

  // ===========================================================
  // sequencer
  always_comb begin
    next_r = r;
    next_r.cyc_start = 1'b0;
    if (tick) begin
      next_r.div_cnt = 8'h00;
      next_r.phase = ffp_phase_t'(r.phase + 2'b01);
      next_r.phase_oh = {r.phase_oh[2:0], r.phase_oh[3]};
      unique case (r.phase)
        FFP_PH1: begin
          // fetch overlaps execution of exec_ir in phases 2-4
          // held during the second extended cycle: the word already
          // prefetched has not been executed yet and must survive
          if (r.state != FFP_ST_EXT2) begin
            next_r.fetched = prog_data;
            next_r.fetched_valid = 1'b1;
            next_r.pc = r.pc + 13'h0001;
          end
        end
        FFP_PH2, FFP_PH3: begin
          // decode window, no state change
        end
        FFP_PH4: begin
          // end of instruction cycle
          next_r.cyc_start = 1'b1;
          unique case (r.state)
            FFP_ST_NORMAL: begin
              if (r.exec_valid && (opc == OPC_ALU || is_ext)) begin
                next_r.acc = alu_res[DATA_W-1:0];
                next_r.cf = alu_res[DATA_W];
                next_r.zf = (alu_res[DATA_W-1:0] == 8'h00);
              end
              if (is_branch) begin
                // first cycle obtains target
                next_r.state = FFP_ST_BRANCH;
                next_r.exec_valid = 1'b0;
                next_r.pc = r.exec_ir[PC_W-1:0];
                next_r.fetched_valid = 1'b0;
              end else if (is_ext) begin
                next_r.state = FFP_ST_EXT2;
                next_r.exec_valid = 1'b0;
              end else if (skip_taken) begin
                // prefetched word is thrown away
                next_r.state = FFP_ST_DUMMY;
                next_r.exec_valid = 1'b0;
              end else begin
                next_r.exec_ir = r.fetched;
                next_r.exec_valid = r.fetched_valid;
              end
            end
            FFP_ST_EXT2: begin
              // second cycle of an extended instruction
              next_r.state = FFP_ST_NORMAL;
              next_r.exec_ir = r.fetched;
              next_r.exec_valid = r.fetched_valid;
            end
            FFP_ST_BRANCH: begin
              // target word was fetched in this cycle; run it next
              next_r.exec_ir = r.fetched;
              next_r.exec_valid = r.fetched_valid;
              next_r.state = FFP_ST_NORMAL;
            end
            FFP_ST_DUMMY: begin
              // dummy cycle done, fetched word is the correct one
              next_r.exec_ir = r.fetched;
              next_r.exec_valid = r.fetched_valid;
              next_r.state = FFP_ST_NORMAL;
            end
          endcase
        end
      endcase
    end else begin
      next_r.div_cnt = r.div_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r.div_cnt <= 8'h00;
      r.phase <= FFP_PH1;
      r.phase_oh <= 4'h1;
      r.state <= FFP_ST_NORMAL;
      r.pc <= RESET_VECTOR;
      r.fetched <= 16'h0000;
      r.fetched_valid <= 1'b0;
      r.exec_ir <= 16'h0000;
      r.exec_valid <= 1'b0;
      r.acc <= ACC_RESET;
      r.zf <= 1'b0;
      r.cf <= 1'b0;
      r.cyc_start <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ===========================================================
  // outputs
  assign prog_addr = r.pc;
  assign prog_rd = (r.phase == FFP_PH1) && tick && !rst &&
    (r.state != FFP_ST_EXT2);
  assign instruction_phase_clocks = r.phase_oh;
  assign cycle_start = r.cyc_start;
  assign pc = r.pc;
  assign acc = r.acc;
  assign zero_flag = r.zf;
  assign carry_flag = r.cf;
  assign seq_state = r.state;
  assign exec_valid = r.exec_valid;

endmodule
`default_nettype wire

// *** verification/ffp_pipeline_props.sv ***
/* Assertion checker bound to ffp_pipeline.
   Assumes osc_select only changes while rst is high. */
`timescale 1ns/1ns
`default_nettype none
module ffp_props
  import ffp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] osc_select,
  input wire logic prog_rd,
  input wire logic [3:0] instruction_phase_clocks,
  input wire logic cycle_start,
  input wire logic [PC_W-1:0] pc,
  input wire logic [DATA_W-1:0] acc
);
  logic [3:0] ph;
  logic [3:0] rot;
  assign ph = instruction_phase_clocks;
  assign rot = {ph[2:0], ph[3]};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ============================================
  // phase sequencing
  sequence s_hold7;
    $stable(ph)[*7] ##1 $changed(ph);
  endsequence
  sequence s_fetch;
    ph == 4'h1 ##1 ph == 4'h2;
  endsequence
  a_phase_onehot: assert property ($onehot(ph))
    else $error("phase not one-hot");
  a_phase_order: assert property (
    $changed(ph) |-> ph == $past(rot)) else $error("phase order");
  a_fast_step: assert property (
    osc_select == FFP_SRC_EXT_FAST |=> ph == $past(rot))
    else $error("fast source not stepping");
  a_slow_hold: assert property (
    $changed(ph) && osc_select == FFP_SRC_EXT_SLOW |=> s_hold7)
    else $error("slow phase length");
  a_fetch_phase: assert property (prog_rd |-> s_fetch)
    else $error("fetch outside phase one");
  a_pc_step: assert property (
    prog_rd |=> pc == $past(pc) + 13'h1) else $error("pc not stepped");
  a_start_pulse: assert property (
    cycle_start |-> ph == 4'h1 && $past(ph) == 4'h8 ##1 !cycle_start)
    else $error("cycle start misplaced");
  a_reset_start: assert property (
    $fell(rst) |-> pc == RESET_VECTOR && ph == 4'h1)
    else $error("reset state");
  a_exec_late: assert property (
    $changed(acc) |-> $past(ph) == 4'h8) else $error("early execute");
endmodule
bind ffp_pipeline ffp_props ffp_props_i (.mclk(mclk), .rst(rst),
  .osc_select(osc_select), .prog_rd(prog_rd),
  .instruction_phase_clocks(instruction_phase_clocks),
  .cycle_start(cycle_start), .pc(pc), .acc(acc));
`default_nettype wire

// *** verification/ffp_prog_mem.sv ***
/* Program memory model, 64 words, aliased by address.
   Assumes the bench fills mem directly. */
`timescale 1ns/1ns
`default_nettype none
module ffp_prog_mem
  import ffp_pkg::*;
(
  input wire logic mclk,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic prog_rd,
  output logic [INSTR_W-1:0] prog_data
);
  logic [INSTR_W-1:0] mem [0:63];
  logic [INSTR_W-1:0] last = 16'h0000;
  always @(posedge mclk)
    if (prog_rd)
      last <= prog_data;
  // inverse outside a fetch so a late sample is caught
  assign prog_data = prog_rd ? mem[prog_addr[5:0]] : ~last;
endmodule
`default_nettype wire

// *** verification/four_phase_fetch_execute_pipeline_tb.sv ***
/* Self-checking bench for ffp_pipeline.
   Assumes package, design, memory model and checker compiled first. */
`timescale 1ns/1ns
`default_nettype none
module four_phase_fetch_execute_pipeline_tb;
  import ffp_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] osc_select = 2'b00;
  logic [PC_W-1:0] prog_addr;
  logic prog_rd;
  logic [INSTR_W-1:0] prog_data;
  logic [3:0] ph;
  logic cycle_start;
  logic [PC_W-1:0] pc;
  logic [DATA_W-1:0] acc;
  logic zf;
  logic cf;
  logic [1:0] st;
  logic ev;
  logic [7:0] v = 8'h5A;
  int error_cnt = 0;
  int n_compared = 0;
  always #10 mclk = ~mclk;
  ffp_pipeline ffp_pipeline_i (.mclk(mclk), .rst(rst),
    .osc_select(osc_select), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_data(prog_data), .instruction_phase_clocks(ph),
    .cycle_start(cycle_start), .pc(pc), .acc(acc), .zero_flag(zf),
    .carry_flag(cf), .seq_state(st), .exec_valid(ev));
  ffp_prog_mem ffp_prog_mem_i (.mclk(mclk), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_data(prog_data));
  // ============================================
  // helpers
  function automatic logic [7:0] alu_ref(logic [3:0] op, logic [7:0] a,
    logic [7:0] b);
    case (op)
      ALU_MOV: return b;
      ALU_ADD: return a + b;
      ALU_SUB: return a - b;
      ALU_AND: return a & b;
      ALU_OR: return a | b;
      ALU_XOR: return a ^ b;
      ALU_CPL: return ~a;
      ALU_RR: return {a[0], a[7:1]};
      ALU_RL: return {a[6:0], a[7]};
      ALU_INC: return a + 8'h01;
      default: return a - 8'h01;
    endcase
  endfunction
  function automatic int lim(logic [1:0] s);
    logic [7:0] d [4] = '{DIV_EXT_FAST, DIV_EXT_SLOW, DIV_INT_FAST,
      DIV_INT_SLOW};
    return int'(d[s]);
  endfunction
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // reset lands mid-phase of the previous run on purpose
  task automatic restart(input logic [1:0] s, input logic [15:0] w);
    int k;
    @(posedge mclk);
    #2 rst = 1'b1;
    osc_select = s;
    for (k = 0; k < 64; k++)
      ffp_prog_mem_i.mem[k] = 16'h0000;
    ffp_prog_mem_i.mem[0] = {OPC_ALU, ALU_OR, v};
    ffp_prog_mem_i.mem[1] = w;
    ffp_prog_mem_i.mem[2] = {OPC_ALU, ALU_INC, 8'h00};
    repeat (5) @(posedge mclk);
    #2 rst = 1'b0;
    chk(pc === RESET_VECTOR && ph === 4'h1, "reset state");
    chk(st === 2'b00 && ev === 1'b0, "reset pipeline");
  endtask
  task automatic run_to(input logic [PC_W-1:0] a, output int n);
    int k;
    n = 0;
    for (k = 0; k < 3000; k++) begin
      @(posedge mclk);
      #1;
      if (prog_rd === 1'b1 && prog_addr === a)
        return;
      n += int'(cycle_start === 1'b1);
    end
    chk(1'b0, "fetch never came");
    final_report();
  endtask
  // ============================================
  // main sequence
  initial begin
    int i;
    int n;
    int nb;
    int ex;
    time t;
    logic [15:0] w;
    logic [7:0] imm;
    logic [7:0] e;
    logic [PC_W-1:0] tgt;
    n = $urandom(6927);
    for (i = 0; i < 4; i++) begin
      restart(2'(i), 16'h0000);
      run_to(13'h2, n);
      t = $time;
      run_to(13'h3, n);
      chk(($time - t) / 20 === 4 * (lim(2'(i)) + 1), "cycle");
      $display("source %0d done", i);
    end
    restart(FFP_SRC_EXT_FAST, 16'h0000);
    run_to(13'h6, nb);
    chk(acc === v + 8'h01, "nop acc");
    for (i = 0; i < 16; i++) begin
      v = 8'($urandom_range(255, 1));
      imm = 8'($urandom);
      tgt = 13'h6;
      ex = 1;
      e = v + 8'h01;
      case (i)
        11: begin
          w = {OPC_ALU_EXT, ALU_MOV, imm};
          e = imm + 8'h01;
        end
        12: w = {OPC_JUMP, 12'h002};
        13: begin
          w = {OPC_CALL, 12'h002};
          tgt = 13'h1006;
        end
        14: begin
          w = {OPC_SKIP_Z, 12'h000};
          ex = 0;
        end
        15: begin
          // dummy cycle replaces the skipped word: no net delay
          e = v;
          ex = 0;
        end
        default: begin
          w = {OPC_ALU, 4'(i), imm};
          ex = 0;
          e = alu_ref(4'(i), v, imm) + 8'h01;
        end
      endcase
      if (i == 15)
        w = {OPC_SKIP_NZ, 12'h000};
      restart(FFP_SRC_EXT_FAST, w);
      run_to(tgt, n);
      chk(n === nb + ex, "cycle count");
      chk(acc === e, "acc result");
      chk(zf === (e == 8'h00), "zero flag");
      chk(cf === (e == 8'h00), "carry flag");
      $display("case %0d done", i);
    end
    final_report();
  end
endmodule
`default_nettype wire
